// [src/azd_top.sv]
// zero flag and zero detect mute logic of a six channel audio converter
// assumes the serial audio pins are asynchronous to clk and are synced here;
// control inputs come from the control register logic on clk;
// word clock high carries the left word, data is taken on rising bit clock
`timescale 1ns/1ps
`include "azd_regs.svh"

module azd_top (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   bit_clock,
   input  wire logic                   word_clock,
   input  wire logic                   serial_input_pair1,
   input  wire logic                   serial_input_pair2,
   input  wire logic                   serial_input_pair3,
   input  wire logic                   zero_mute_enable,
   input  wire logic                   general_output_enable,
   input  wire logic [`AZD_CH_NUM-1:0] general_output_value,
   input  wire logic                   output_phase_invert,
   output logic                        zero_flag_ch1,
   output logic                        zero_flag_ch2,
   output logic                        zero_flag_ch3,
   output logic                        zero_flag_ch4,
   output logic                        zero_flag_ch5,
   output logic                        zero_flag_ch6,
   output logic                        all_channel_zero_flag,
   output logic [`AZD_CH_NUM-1:0]      amp_source_common_mode
);
   import azd_pkg::*;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic                     bck_s1_ff;
   logic                     bck_s2_ff;
   logic                     bck_s3_ff;
   logic                     wck_s1_ff;
   logic                     wck_s2_ff;
   logic                     wck_s3_ff;
   logic [`AZD_PAIR_NUM-1:0] dat_s1_ff;
   logic [`AZD_PAIR_NUM-1:0] dat_s2_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bck_s1_ff <= `AZD_BIT_RST;
         bck_s2_ff <= `AZD_BIT_RST;
         bck_s3_ff <= `AZD_BIT_RST;
         wck_s1_ff <= `AZD_BIT_RST;
         wck_s2_ff <= `AZD_BIT_RST;
         wck_s3_ff <= `AZD_BIT_RST;
         dat_s1_ff <= `AZD_PAIR_RST;
         dat_s2_ff <= `AZD_PAIR_RST;
      end else begin
         bck_s1_ff <= bit_clock;
         bck_s2_ff <= bck_s1_ff;
         bck_s3_ff <= bck_s2_ff;
         wck_s1_ff <= word_clock;
         wck_s2_ff <= wck_s1_ff;
         wck_s3_ff <= wck_s2_ff;
         dat_s1_ff <= {serial_input_pair3, serial_input_pair2, serial_input_pair1};
         dat_s2_ff <= dat_s1_ff;
      end
   end

   // edges seen only from the second stage onward
   logic bck_rise;
   logic wck_rise;
   logic wck_fall;

   assign bck_rise = bck_s2_ff & ~bck_s3_ff;
   assign wck_rise = wck_s2_ff & ~wck_s3_ff;
   assign wck_fall = ~wck_s2_ff & wck_s3_ff;

   // ****************************************************************
   // word framing and nonzero collection
   // ****************************************************************
   // spreads the three pair results onto the left or right channel slots
   function automatic azd_frame_t spread(input logic [`AZD_PAIR_NUM-1:0] nz,
                                         input logic                     right);
      azd_frame_t fr;
      fr = '0;
      for (int i = 0; i < `AZD_PAIR_NUM; i++) begin
         fr[2*i + int'(right)].strobe = 1'b1;
         fr[2*i + int'(right)].zero   = ~nz[i];
      end
      return fr;
   endfunction

   azd_state_t               st_ff;
   azd_state_t               nxt_st;
   logic [`AZD_PAIR_NUM-1:0] nz_ff;
   logic [`AZD_PAIR_NUM-1:0] nxt_nz;
   azd_frame_t               smp_ff;
   azd_frame_t               nxt_smp;
   logic [`AZD_PAIR_NUM-1:0] word_nz;

   // a bit taken in the same cycle as the word edge still belongs to the word
   assign word_nz = nz_ff | (bck_rise ? dat_s2_ff : `AZD_PAIR_RST);

   always_comb begin
      nxt_st  = st_ff;
      nxt_nz  = word_nz;
      nxt_smp = '0;
      case (st_ff)
         AZD_ST_IDLE: begin
            // first partial word is dropped
            nxt_nz = `AZD_PAIR_RST;
            if (wck_rise) begin
               nxt_st = AZD_ST_LEFT;
            end else if (wck_fall) begin
               nxt_st = AZD_ST_RIGHT;
            end
         end
         AZD_ST_LEFT: begin
            if (wck_fall) begin
               nxt_smp = spread(word_nz, 1'b0);
               nxt_nz  = `AZD_PAIR_RST;
               nxt_st  = AZD_ST_RIGHT;
            end
         end
         AZD_ST_RIGHT: begin
            if (wck_rise) begin
               nxt_smp = spread(word_nz, 1'b1);
               nxt_nz  = `AZD_PAIR_RST;
               nxt_st  = AZD_ST_LEFT;
            end
         end
         default: begin
            nxt_st = AZD_ST_IDLE;
            nxt_nz = `AZD_PAIR_RST;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff  <= AZD_ST_IDLE;
         nz_ff  <= `AZD_PAIR_RST;
         smp_ff <= '0;
      end else begin
         st_ff  <= nxt_st;
         nz_ff  <= nxt_nz;
         smp_ff <= nxt_smp;
      end
   end

   // ****************************************************************
   // per channel detectors
   // ****************************************************************
   logic [`AZD_CH_NUM-1:0] det;

   for (genvar c = 0; c < `AZD_CH_NUM; c++) begin : g_det
      // each detector sees only its own channel's samples
      azd_chan_det u_det (
         .clk      (clk),
         .rst_n    (rst_n),
         .sample   (smp_ff[c]),
         .zero_det (det[c])
      );
   end

   // ****************************************************************
   // flag pins and mute controls
   // ****************************************************************
   logic [`AZD_CH_NUM-1:0] flag_raw;
   logic [`AZD_CH_NUM-1:0] flag_ff;
   logic [`AZD_CH_NUM-1:0] nxt_flag;
   logic                   all_ff;
   logic                   nxt_all;
   logic [`AZD_CH_NUM-1:0] mute_ff;
   logic [`AZD_CH_NUM-1:0] nxt_mute;

   always_comb begin
      // one detection result feeds both flags and mute
      flag_raw = det & {`AZD_CH_NUM{~output_phase_invert}};
      nxt_flag = general_output_enable ? general_output_value : flag_raw;
      nxt_all  = &flag_raw;
      nxt_mute = flag_raw & {`AZD_CH_NUM{zero_mute_enable}};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= `AZD_CH_RST;
         all_ff  <= `AZD_BIT_RST;
         mute_ff <= `AZD_CH_RST;
      end else begin
         flag_ff <= nxt_flag;
         all_ff  <= nxt_all;
         mute_ff <= nxt_mute;
      end
   end

   assign zero_flag_ch1          = flag_ff[0];
   assign zero_flag_ch2          = flag_ff[1];
   assign zero_flag_ch3          = flag_ff[2];
   assign zero_flag_ch4          = flag_ff[3];
   assign zero_flag_ch5          = flag_ff[4];
   assign zero_flag_ch6          = flag_ff[5];
   assign all_channel_zero_flag  = all_ff;
   // high selects the common mode reference instead of the modulator
   assign amp_source_common_mode = mute_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_FLAG_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
      (!output_phase_invert && !general_output_enable) |=> (flag_ff == $past(det)))
      else $error("flag pins do not follow the detectors");

   AST_GPO_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
      general_output_enable |=> (flag_ff == $past(general_output_value)))
      else $error("general output value missing on flag pins");

   AST_ALL_AND: assert property (@(posedge clk) disable iff (!rst_n)
      !output_phase_invert |=> (all_ff == &$past(det)))
      else $error("combined flag is not the AND of the channels");

   AST_MUTE_SET: assert property (@(posedge clk) disable iff (!rst_n)
      (zero_mute_enable && !output_phase_invert) |=> (amp_source_common_mode == $past(det)))
      else $error("mute does not follow detection at once");

   AST_MUTE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      !zero_mute_enable |=> (amp_source_common_mode == `AZD_CH_RST))
      else $error("mute active while disabled");

   AST_SHARED: assert property (@(posedge clk) disable iff (!rst_n)
      (zero_mute_enable && !general_output_enable) |=> (amp_source_common_mode == flag_ff))
      else $error("flag and mute disagree");

   AST_INVERT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (output_phase_invert && !general_output_enable) |=> (flag_ff == `AZD_CH_RST) && !all_ff
                                                          && (mute_ff == `AZD_CH_RST))
      else $error("zero functions active during phase invert");

   AST_LEFT_SLOT: assert property (@(posedge clk) disable iff (!rst_n)
      (st_ff == AZD_ST_LEFT && wck_fall) |=> smp_ff[0].strobe && smp_ff[2].strobe
                                             && !smp_ff[1].strobe && !smp_ff[5].strobe)
      else $error("left word not delivered to odd channels");

   AST_NZ_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      (smp_ff[0].strobe && !smp_ff[0].zero) |=> !det[0] ##1 ($past(general_output_enable) || !flag_ff[0]))
      else $error("nonzero sample did not clear channel 1");

   COV_ALL_ZERO: cover property (@(posedge clk) disable iff (!rst_n) $rose(all_ff));
   COV_MUTE:     cover property (@(posedge clk) disable iff (!rst_n) $rose(mute_ff[3]));
   COV_GPO:      cover property (@(posedge clk) disable iff (!rst_n)
                                 general_output_enable && (flag_ff != `AZD_CH_RST));
   COV_RELEASE:  cover property (@(posedge clk) disable iff (!rst_n) $fell(flag_ff[0]));
endmodule

// [src/azd_regs.svh]
// constants of the zero detect block: counts, widths, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef AZD_REGS_SVH
`define AZD_REGS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define AZD_CH_NUM     6
`define AZD_PAIR_NUM   3
`define AZD_CNT_W      11

// ****************************************************************
// timing counts
// ****************************************************************
// zero samples in a row before a channel counts as silent
`define AZD_ZERO_RUN   11'h400
`define AZD_CNT_ONE    11'h001

// ****************************************************************
// reset values
// ****************************************************************
`define AZD_CNT_RST    11'h000
`define AZD_CH_RST     6'h00
`define AZD_PAIR_RST   3'h0
`define AZD_BIT_RST    1'b0

`endif

// [src/azd_pkg.sv]
// types of the zero detect block
// assumes azd_regs.svh is on the include path
`include "azd_regs.svh"

package azd_pkg;

   // ****************************************************************
   // one finished word of one channel
   // ****************************************************************
   typedef struct packed {
      logic strobe;
      logic zero;
   } azd_smp_t;

   typedef azd_smp_t [`AZD_CH_NUM-1:0] azd_frame_t;

   // ****************************************************************
   // word framing states
   // ****************************************************************
   typedef enum logic [2:0] {
      AZD_ST_IDLE  = 3'b001,
      AZD_ST_LEFT  = 3'b010,
      AZD_ST_RIGHT = 3'b100
   } azd_state_t;

endpackage

// [src/azd_chan_det.sv]
// zero run detector for one audio channel
// assumes one sample strobe per word of its own channel, on clk
`timescale 1ns/1ps
`include "azd_regs.svh"

module azd_chan_det (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire azd_pkg::azd_smp_t sample,
   output logic                  zero_det
);
   import azd_pkg::*;

   logic [`AZD_CNT_W-1:0] cnt_ff;
   logic [`AZD_CNT_W-1:0] nxt_cnt;

   // ****************************************************************
   // run counter, saturates at the limit
   // ****************************************************************
   always_comb begin
      nxt_cnt = cnt_ff;
      if (sample.strobe) begin
         if (!sample.zero) begin
            nxt_cnt = `AZD_CNT_RST;
         end else if (cnt_ff != `AZD_ZERO_RUN) begin
            nxt_cnt = cnt_ff + `AZD_CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= `AZD_CNT_RST;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign zero_det = (cnt_ff == `AZD_ZERO_RUN);

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_DET_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      (sample.strobe && !sample.zero) |=> (cnt_ff == `AZD_CNT_RST) && !zero_det)
      else $error("nonzero sample did not clear the run");

   AST_DET_REACH: assert property (@(posedge clk) disable iff (!rst_n)
      (sample.strobe && sample.zero && cnt_ff == `AZD_ZERO_RUN - `AZD_CNT_ONE) |=> zero_det)
      else $error("zero detect not raised at the run limit");

   AST_DET_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(zero_det) |-> $past(sample.strobe) && $past(sample.zero))
      else $error("zero detect raised without a zero sample");

   AST_DET_OWN: assert property (@(posedge clk) disable iff (!rst_n)
      !sample.strobe |=> $stable(cnt_ff))
      else $error("run counter moved without its own sample");

   COV_DET_FULL: cover property (@(posedge clk) disable iff (!rst_n) $rose(zero_det));
endmodule

// [tb/azd_audio_src.sv]
// serial audio source model: three data lines, left and right words of two bits each
// assumes send_frame is called from a process at a rising edge of clk
`timescale 1ns/1ps

module azd_audio_src (
   input  wire logic clk,
   output logic      bit_clock,
   output logic      word_clock,
   output logic      serial_input_pair1,
   output logic      serial_input_pair2,
   output logic      serial_input_pair3
);
   import azd_pkg::*;

   initial begin
      bit_clock          = 1'b0;
      word_clock         = 1'b0;
      serial_input_pair1 = 1'b0;
      serial_input_pair2 = 1'b0;
      serial_input_pair3 = 1'b0;
   end

   // ****************************************************************
   // one frame: left half with word clock high, then right half
   // ****************************************************************
   // w[2c+1:2c] is the word of channel c+1, msb sent first
   task automatic send_frame(input logic [11:0] w);
      int h;
      int b;
      for (h = 0; h < 2; h++) begin
         for (b = 1; b >= 0; b--) begin
            word_clock         <= (h == 0);
            serial_input_pair1 <= w[2*(0+h)+b];
            serial_input_pair2 <= w[2*(2+h)+b];
            serial_input_pair3 <= w[2*(4+h)+b];
            bit_clock          <= 1'b0;
            repeat (4) @(posedge clk);
            bit_clock          <= 1'b1;
            repeat (4) @(posedge clk);
         end
      end
      // bit clock stands still and released data no longer shows the last bit
      bit_clock          <= 1'b0;
      serial_input_pair1 <= ~serial_input_pair1;
      serial_input_pair2 <= ~serial_input_pair2;
      serial_input_pair3 <= ~serial_input_pair3;
   endtask

endmodule

// [tb/tb.sv]
// self checking bench of the zero flag and zero detect mute block
// assumes the source model sends whole frames; expectations come from a count model
`timescale 1ns/1ps
`include "azd_regs.svh"

module tb;
   import azd_pkg::*;

   localparam int ZERO_RUN = 1024;

   logic                   clk;
   logic                   rst_n;
   logic                   bit_clock;
   logic                   word_clock;
   logic                   serial_input_pair1;
   logic                   serial_input_pair2;
   logic                   serial_input_pair3;
   logic                   zero_mute_enable;
   logic                   general_output_enable;
   logic [`AZD_CH_NUM-1:0] general_output_value;
   logic                   output_phase_invert;
   logic [5:0]             flags;
   logic                   all_channel_zero_flag;
   logic [`AZD_CH_NUM-1:0] amp_source_common_mode;
   int                     error_cnt;
   int                     total_checks;
   int                     cnt [6];
   int                     i;

   // ****************************************************************
   // design and source model
   // ****************************************************************
   azd_top azd_top_inst (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .bit_clock              (bit_clock),
      .word_clock             (word_clock),
      .serial_input_pair1     (serial_input_pair1),
      .serial_input_pair2     (serial_input_pair2),
      .serial_input_pair3     (serial_input_pair3),
      .zero_mute_enable       (zero_mute_enable),
      .general_output_enable  (general_output_enable),
      .general_output_value   (general_output_value),
      .output_phase_invert    (output_phase_invert),
      .zero_flag_ch1          (flags[0]),
      .zero_flag_ch2          (flags[1]),
      .zero_flag_ch3          (flags[2]),
      .zero_flag_ch4          (flags[3]),
      .zero_flag_ch5          (flags[4]),
      .zero_flag_ch6          (flags[5]),
      .all_channel_zero_flag  (all_channel_zero_flag),
      .amp_source_common_mode (amp_source_common_mode)
   );

   azd_audio_src azd_audio_src_inst (
      .clk                (clk),
      .bit_clock          (bit_clock),
      .word_clock         (word_clock),
      .serial_input_pair1 (serial_input_pair1),
      .serial_input_pair2 (serial_input_pair2),
      .serial_input_pair3 (serial_input_pair3)
   );

   always #4 clk = ~clk;

   // ****************************************************************
   // checking helpers
   // ****************************************************************
   task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic upd(input int c, input logic nz);
      cnt[c] = nz ? 0 : ((cnt[c] < ZERO_RUN) ? cnt[c] + 1 : ZERO_RUN);
   endtask

   task automatic check_outputs();
      logic [5:0] d;
      logic [5:0] ef;
      for (int c = 0; c < 6; c++) begin
         d[c] = (cnt[c] >= ZERO_RUN);
      end
      ef = general_output_enable ? general_output_value : (output_phase_invert ? 6'h00 : d);
      chk("zero_flags", ef, flags);
      chk("all_flag", {5'h00, ~output_phase_invert & (&d)}, {5'h00, all_channel_zero_flag});
      chk("amp_source", (zero_mute_enable & ~output_phase_invert) ? d : 6'h00, amp_source_common_mode);
   endtask

   task automatic check_idle(input string nm);
      chk(nm, 6'h00, flags);
      chk(nm, 6'h00, {5'h00, all_channel_zero_flag});
      chk(nm, 6'h00, amp_source_common_mode);
   endtask

   // ****************************************************************
   // reset and frame drivers
   // ****************************************************************
   task automatic do_reset();
      @(posedge clk);
      rst_n                 <= 1'b0;
      zero_mute_enable      <= 1'b0;
      general_output_enable <= 1'b0;
      general_output_value  <= 6'h00;
      output_phase_invert   <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check_idle("reset_out");
      @(posedge clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 6; c++) begin
         cnt[c] = 0;
      end
      @(posedge clk);
      #1 check_idle("release_out");
   endtask

   // nz marks channels that get a random nonzero word; ctl draws new controls
   task automatic run_frame(input logic [5:0] nz, input logic ctl);
      logic [11:0] w;
      for (int c = 0; c < 6; c++) begin
         w[2*c+:2] = nz[c] ? 2'($urandom_range(1, 3)) : 2'b00;
      end
      @(posedge clk);
      if (ctl) begin
         zero_mute_enable      <= 1'($urandom_range(0, 1));
         general_output_enable <= ($urandom_range(0, 3) == 0);
         general_output_value  <= 6'($urandom);
         output_phase_invert   <= ($urandom_range(0, 7) == 0);
      end
      azd_audio_src_inst.send_frame(w);
      // left words end at the falling word clock, right words at the next rise
      for (int c = 0; c < 6; c += 2) begin
         upd(c, nz[c]);
      end
      #1 check_outputs();
      for (int c = 1; c < 6; c += 2) begin
         upd(c, nz[c]);
      end
   endtask

   // ****************************************************************
   // verdict, watchdog and main sequence
   // ****************************************************************
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      clk                   = 1'b0;
      rst_n                 = 1'b0;
      zero_mute_enable      = 1'b0;
      general_output_enable = 1'b0;
      general_output_value  = 6'h00;
      output_phase_invert   = 1'b0;
      error_cnt             = 0;
      total_checks          = 0;
      void'($urandom(32'h627d));
      do_reset();
      // ch4 breaks its run early, before any channel is silent, ch1 breaks after all channels were silent
      for (i = 0; i < 1141; i++) begin
         run_frame((i == 0) ? 6'h3f : (i == 100) ? 6'h08 : (i == 1135) ? 6'h01 : 6'h00, i > 0);
      end
      do_reset();
      for (i = 0; i < 40; i++) begin
         run_frame((i == 0) ? 6'h3f : 6'($urandom), i > 0);
      end
      print_verdict();
   end

endmodule
